// File: verilog/cfws_top.v
// Configuration fuses, watchdog and two-speed start-up with APB access
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "cfws_defines.vh"
module cfws_top #(
  parameter WDT_BASE_CYC = `CFWS_WDT_BASE_CYC,
  parameter [10:0] PART_CODE = 11'h2A5, // Arbitrary value
  parameter [4:0] REVISION_CODE = 5'h03 // Arbitrary value
) (
  input wire I_CLOCK,
  input wire I_SYS_RST,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [23:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output wire [31:0] O_PRDATA,
  output wire O_PREADY,
  output wire O_PSLVERR,
  input wire I_MASTER_CLEAR_PIN_N,
  input wire I_OST_DONE,
  input wire I_PWRT_DONE,
  input wire I_SLEEP,
  input wire I_WATCHDOG_CLEAR_INSTR,
  input wire I_CLOCK_FAIL,
  input wire I_WAKE,
  input wire I_STACK_FULL,
  input wire I_STACK_UNDERFLOW,
  input wire I_TBLRD_REQ,
  input wire I_TBLRD_FROM_EXT,
  input wire [20:0] I_TBLRD_ADDR,
  output wire O_MASTER_RESET,
  output wire O_PORT_G_BIT5_IN_EN,
  output wire O_PORT_G_BIT5_DATA,
  output wire O_TIMER1_LOW_POWER_OSC,
  output wire O_CAPTURE_COMPARE_UNIT2_ON_PORT_C_BIT1,
  output wire O_CAPTURE_COMPARE_UNIT2_ON_PORT_E_BIT7,
  output wire O_CAPTURE_COMPARE_UNIT2_ON_PORT_B_BIT3,
  output wire O_DEBUGGER_EN,
  output wire O_PORT_B_PINS_GPIO,
  output wire O_EXTENDED_INSTR_EN,
  output wire O_STACK_FAULT_RESET,
  output wire O_TBLRD_BLOCK,
  output wire O_WATCHDOG_RESET,
  output wire O_INTERNAL_RC_OSC_EN,
  output wire O_CORE_ON_INTERNAL_OSC,
  output wire [2:0] O_INTERNAL_OSC_FREQ_SELECT
);
  localparam [3:0] S_NONE = 4'h0;
  localparam [3:0] S_CFG1H = 4'h1;
  localparam [3:0] S_CFG2H = 4'h2;
  localparam [3:0] S_CFG3L = 4'h3;
  localparam [3:0] S_CFG3H = 4'h4;
  localparam [3:0] S_CFG4L = 4'h5;
  localparam [3:0] S_CFG5L = 4'h6;
  localparam [3:0] S_CFG7L = 4'h7;
  localparam [3:0] S_ID1 = 4'h8;
  localparam [3:0] S_ID2 = 4'h9;
  localparam [3:0] S_WATCHDOG_CONTROL = 4'hA;
  localparam [3:0] S_OSCCTL = 4'hB;
  localparam [3:0] S_STATUS = 4'hC;
  localparam [1:0] TS_PRIMARY = 2'h0;
  localparam [1:0] TS_WAIT_PWRT = 2'h1;
  localparam [1:0] TS_INTERNAL = 2'h2;

  function [3:0] cfws_sel;
    input [21:0] idx;
    begin
      case (idx)
        `CFWS_IDX_CFG1H: cfws_sel = S_CFG1H;
        `CFWS_IDX_CFG2H: cfws_sel = S_CFG2H;
        `CFWS_IDX_CFG3L: cfws_sel = S_CFG3L;
        `CFWS_IDX_CFG3H: cfws_sel = S_CFG3H;
        `CFWS_IDX_CFG4L: cfws_sel = S_CFG4L;
        `CFWS_IDX_CFG5L: cfws_sel = S_CFG5L;
        `CFWS_IDX_CFG7L: cfws_sel = S_CFG7L;
        `CFWS_IDX_ID1: cfws_sel = S_ID1;
        `CFWS_IDX_ID2: cfws_sel = S_ID2;
        `CFWS_IDX_WATCHDOG_CONTROL: cfws_sel = S_WATCHDOG_CONTROL;
        `CFWS_IDX_OSCCTL: cfws_sel = S_OSCCTL;
        `CFWS_IDX_STATUS: cfws_sel = S_STATUS;
        default: cfws_sel = S_NONE;
      endcase
    end
  endfunction

  reg [7:0] cfg1h_q;
  reg [7:0] cfg2h_q;
  reg [7:0] cfg3l_q;
  reg [7:0] cfg3h_q;
  reg [7:0] cfg4l_q;
  reg [7:0] cfg5l_q;
  reg [7:0] cfg7l_q;
  reg [7:0] watchdog_control_q;
  reg [7:0] oscctl_q;
  reg pready_q;
  reg pslverr_q;
  reg [31:0] prdata_q;
  reg [7:0] rd_byte;
  reg wdt_clr_q;
  reg start_q;
  reg [1:0] ts_q;
  reg [1:0] ts_d;
  reg on_internal_osc_block_q;
  reg mreset_q;
  reg g5_en_q;
  reg g5_data_q;
  reg t1lp_q;
  reg ccp_c1_q;
  reg ccp_e7_q;
  reg ccp_b3_q;
  reg dbg_q;
  reg pb_gpio_q;
  reg extended_instr_enable_q;
  reg stk_rst_q;
  reg tblk_q;
  reg rc_en_q;
  wire [1:0] sync_out;
  wire master_clear_pin_pin_s = sync_out[0];
  wire ost_done_s = sync_out[1];
  wire wdt_tmo;

  cfws_sync #(
    .W(2),
    .INIT(2'b01)
  ) u_sync (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_d({I_OST_DONE, I_MASTER_CLEAR_PIN_N}),
    .o_q(sync_out)
  );

  // APB: one wait state, the answer comes on the second access cycle
  wire [3:0] sel = (I_PADDR[1:0] == 2'b00) ? cfws_sel(I_PADDR[23:2]) : S_NONE;
  wire acc = I_PSEL & I_PENABLE & ~pready_q;
  wire wr = I_PSEL & I_PENABLE & pready_q & I_PWRITE & ~pslverr_q;
  wire [7:0] wb = I_PWDATA[7:0];
  wire ircf_chg = wr & (sel == S_OSCCTL) & ((wb & `CFWS_MSK_OSCCTL) != oscctl_q);

  wire wdt_en = cfg2h_q[`CFWS_B_FUSE_WATCHDOG_ENABLE] | watchdog_control_q[0];
  wire [3:0] wdt_ps = cfg2h_q[`CFWS_B_PS_HI:`CFWS_B_PS_LO];
  wire two_speed_start_enable = cfg1h_q[`CFWS_B_TWO_SPEED_START_ENABLE];
  wire [1:0] pm = cfg3l_q[1:0];

  always @* begin
    case (sel)
      S_CFG1H: rd_byte = cfg1h_q;
      S_CFG2H: rd_byte = cfg2h_q;
      S_CFG3L: rd_byte = cfg3l_q;
      S_CFG3H: rd_byte = cfg3h_q;
      S_CFG4L: rd_byte = cfg4l_q;
      S_CFG5L: rd_byte = cfg5l_q;
      S_CFG7L: rd_byte = cfg7l_q;
      S_ID1: rd_byte = {PART_CODE[2:0], REVISION_CODE};
      S_ID2: rd_byte = PART_CODE[10:3];
      S_WATCHDOG_CONTROL: rd_byte = watchdog_control_q;
      S_OSCCTL: rd_byte = oscctl_q;
      S_STATUS: rd_byte = {4'h0, rc_en_q, wdt_en, ts_q != TS_PRIMARY, ts_q == TS_PRIMARY};
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= acc;
      if (acc) begin
        pslverr_q <= (sel == S_NONE);
        prdata_q <= {24'h000000, rd_byte};
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Unimplemented bits are masked on write so they always read zero
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      cfg1h_q <= `CFWS_RST_CFG1H;
      cfg2h_q <= `CFWS_RST_CFG2H;
      cfg3l_q <= `CFWS_RST_CFG3L;
      cfg3h_q <= `CFWS_RST_CFG3H;
      cfg4l_q <= `CFWS_RST_CFG4L;
      cfg5l_q <= `CFWS_RST_BIT0;
      cfg7l_q <= `CFWS_RST_BIT0;
      watchdog_control_q <= 8'h00;
      oscctl_q <= `CFWS_RST_OSCCTL;
    end else if (wr) begin
      case (sel)
        S_CFG1H: cfg1h_q <= wb & `CFWS_MSK_CFG1H;
        S_CFG2H: cfg2h_q <= wb & `CFWS_MSK_CFG2H;
        S_CFG3L: cfg3l_q <= wb & `CFWS_MSK_CFG3L;
        S_CFG3H: cfg3h_q <= wb & `CFWS_MSK_CFG3H;
        S_CFG4L: cfg4l_q <= wb & `CFWS_MSK_CFG4L;
        // Clear-only cells: a write can program 0 but never erase
        S_CFG5L: cfg5l_q <= cfg5l_q & wb & `CFWS_MSK_BIT0;
        S_CFG7L: cfg7l_q <= cfg7l_q & wb & `CFWS_MSK_BIT0;
        S_WATCHDOG_CONTROL: watchdog_control_q <= wb & `CFWS_MSK_BIT0;
        S_OSCCTL: oscctl_q <= wb & `CFWS_MSK_OSCCTL;
        default: oscctl_q <= oscctl_q;
      endcase
    end
  end

  // Watchdog clear sources, registered to ease timing into the counter
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wdt_clr_q <= 1'b0;
    end else begin
      wdt_clr_q <= I_SLEEP | I_WATCHDOG_CLEAR_INSTR | I_CLOCK_FAIL | ircf_chg;
    end
  end

  cfws_wdt #(
    .BASE_CYC(WDT_BASE_CYC)
  ) u_wdt (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_en(wdt_en),
    .i_clr(wdt_clr_q),
    .i_ps(wdt_ps),
    .o_tmo(wdt_tmo)
  );

  // Two-speed start-up; other mode changes never enter it
  wire go = start_q | I_WAKE;
  always @* begin
    ts_d = ts_q;
    case (ts_q)
      TS_PRIMARY: begin
        if (go & two_speed_start_enable) begin
          ts_d = TS_WAIT_PWRT;
        end
      end
      TS_WAIT_PWRT: begin
        if (I_PWRT_DONE) begin
          ts_d = TS_INTERNAL;
        end
      end
      TS_INTERNAL: begin
        if (ost_done_s) begin
          ts_d = TS_PRIMARY;
        end
      end
      default: ts_d = TS_PRIMARY;
    endcase
  end

  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      start_q <= 1'b1;
      ts_q <= TS_PRIMARY;
      on_internal_osc_block_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      ts_q <= ts_d;
      on_internal_osc_block_q <= (ts_d == TS_INTERNAL);
    end
  end

  // Table read protection depends on processor memory mode
  wire tb_hit = (pm == `CFWS_PM_EXT) ? (I_TBLRD_ADDR <= `CFWS_INTMEM_TOP) :
                (pm == `CFWS_PM_BOOT) ? (I_TBLRD_ADDR <= `CFWS_BOOT_TOP) : 1'b0;

  // Decoded fuse functions, all registered so outputs come from flops
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      mreset_q <= 1'b0;
      g5_en_q <= 1'b0;
      g5_data_q <= 1'b0;
      t1lp_q <= 1'b0;
      ccp_c1_q <= 1'b0;
      ccp_e7_q <= 1'b0;
      ccp_b3_q <= 1'b0;
      dbg_q <= 1'b0;
      pb_gpio_q <= 1'b0;
      extended_instr_enable_q <= 1'b0;
      stk_rst_q <= 1'b0;
      tblk_q <= 1'b0;
      rc_en_q <= 1'b0;
    end else begin
      mreset_q <= cfg3h_q[`CFWS_B_RSTPIN] & ~master_clear_pin_pin_s;
      g5_en_q <= ~cfg3h_q[`CFWS_B_RSTPIN];
      g5_data_q <= ~cfg3h_q[`CFWS_B_RSTPIN] & master_clear_pin_pin_s;
      t1lp_q <= cfg3h_q[`CFWS_B_T1LP];
      ccp_c1_q <= cfg3h_q[`CFWS_B_CAPTURE_COMPARE_UNIT2];
      ccp_e7_q <= ~cfg3h_q[`CFWS_B_CAPTURE_COMPARE_UNIT2] & (pm == `CFWS_PM_MCU);
      ccp_b3_q <= ~cfg3h_q[`CFWS_B_CAPTURE_COMPARE_UNIT2] & (pm != `CFWS_PM_MCU);
      dbg_q <= ~cfg4l_q[`CFWS_B_DEBUG];
      pb_gpio_q <= cfg4l_q[`CFWS_B_DEBUG];
      extended_instr_enable_q <= cfg4l_q[`CFWS_B_EXTENDED_INSTR_ENABLE];
      stk_rst_q <= cfg4l_q[`CFWS_B_STACK] & (I_STACK_FULL | I_STACK_UNDERFLOW);
      // Code protect is advisory here; only the read port is gated
      tblk_q <= I_TBLRD_REQ & I_TBLRD_FROM_EXT & ~cfg7l_q[0] & tb_hit;
      // Watchdog needs the internal RC; start-up uses the same block
      rc_en_q <= wdt_en | (ts_d != TS_PRIMARY);
    end
  end

  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_MASTER_RESET = mreset_q;
  assign O_PORT_G_BIT5_IN_EN = g5_en_q;
  assign O_PORT_G_BIT5_DATA = g5_data_q;
  assign O_TIMER1_LOW_POWER_OSC = t1lp_q;
  assign O_CAPTURE_COMPARE_UNIT2_ON_PORT_C_BIT1 = ccp_c1_q;
  assign O_CAPTURE_COMPARE_UNIT2_ON_PORT_E_BIT7 = ccp_e7_q;
  assign O_CAPTURE_COMPARE_UNIT2_ON_PORT_B_BIT3 = ccp_b3_q;
  assign O_DEBUGGER_EN = dbg_q;
  assign O_PORT_B_PINS_GPIO = pb_gpio_q;
  assign O_EXTENDED_INSTR_EN = extended_instr_enable_q;
  assign O_STACK_FAULT_RESET = stk_rst_q;
  assign O_TBLRD_BLOCK = tblk_q;
  assign O_WATCHDOG_RESET = wdt_tmo;
  assign O_INTERNAL_RC_OSC_EN = rc_en_q;
  assign O_CORE_ON_INTERNAL_OSC = on_internal_osc_block_q;
  assign O_INTERNAL_OSC_FREQ_SELECT = oscctl_q[2:0];
endmodule // cfws_top

// File: verilog/cfws_defines.vh
// Register indices, field positions, reset values and timing counts
`ifndef CFWS_DEFINES_VH
`define CFWS_DEFINES_VH
`define CFWS_IDX_CFG1H 22'h300001
`define CFWS_IDX_CFG2H 22'h300003
`define CFWS_IDX_CFG3L 22'h300004
`define CFWS_IDX_CFG3H 22'h300005
`define CFWS_IDX_CFG4L 22'h300006
`define CFWS_IDX_CFG5L 22'h300008
`define CFWS_IDX_CFG7L 22'h30000C
`define CFWS_IDX_ID1 22'h3FFFFE
`define CFWS_IDX_ID2 22'h3FFFFF
`define CFWS_IDX_WATCHDOG_CONTROL 22'h000100
`define CFWS_IDX_OSCCTL 22'h000101
`define CFWS_IDX_STATUS 22'h000102
`define CFWS_MSK_CFG1H 8'h80
`define CFWS_MSK_CFG2H 8'h1F
`define CFWS_MSK_CFG3L 8'h03
`define CFWS_MSK_CFG3H 8'h85
`define CFWS_MSK_CFG4L 8'hC1
`define CFWS_MSK_BIT0 8'h01
`define CFWS_MSK_OSCCTL 8'h07
`define CFWS_RST_CFG1H 8'h00
`define CFWS_RST_CFG2H 8'h1F
`define CFWS_RST_CFG3L 8'h03
`define CFWS_RST_CFG3H 8'h81
`define CFWS_RST_CFG4L 8'h81
`define CFWS_RST_BIT0 8'h01
`define CFWS_RST_OSCCTL 8'h00
`define CFWS_B_TWO_SPEED_START_ENABLE 7
`define CFWS_B_FUSE_WATCHDOG_ENABLE 0
`define CFWS_B_PS_HI 4
`define CFWS_B_PS_LO 1
`define CFWS_B_RSTPIN 7
`define CFWS_B_T1LP 2
`define CFWS_B_CAPTURE_COMPARE_UNIT2 0
`define CFWS_B_DEBUG 7
`define CFWS_B_EXTENDED_INSTR_ENABLE 6
`define CFWS_B_STACK 0
`define CFWS_PM_MCU 2'h3
`define CFWS_PM_MPU 2'h2
`define CFWS_PM_BOOT 2'h1
`define CFWS_PM_EXT 2'h0
`define CFWS_BOOT_TOP 21'h0007FF
`define CFWS_INTMEM_TOP 21'h00FFFF
`define CFWS_CLK_NS 5
`define CFWS_WDT_BASE_NS 4000000
`define CFWS_WDT_BASE_CYC (`CFWS_WDT_BASE_NS / `CFWS_CLK_NS)
`endif

// File: verilog/cfws_sync.v
// Two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module cfws_sync #(
  parameter W = 2,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire i_clk,
  input wire i_rst,
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end
  assign o_q = sync_q;
endmodule // cfws_sync

// File: verilog/cfws_wdt.v
// Watchdog base divider and 16-bit postscaler with tap select
`timescale 1ns/1ps
`include "cfws_defines.vh"
module cfws_wdt #(
  parameter BASE_CYC = `CFWS_WDT_BASE_CYC
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_en,
  input wire i_clr,
  input wire [3:0] i_ps,
  output reg o_tmo
);
  localparam integer BASE_LAST_I = BASE_CYC - 1;
  localparam [19:0] BASE_LAST = BASE_LAST_I[19:0];
  reg [19:0] base_q;
  reg [15:0] post_q;
  wire tick = (base_q == BASE_LAST);
  // Tap 2^ps: ratio 1:1 for 0000 up to 1:32768 for 1111
  wire [15:0] tap_last = (16'h0001 << i_ps) - 16'h0001;
  // Tap overflows when its low ps bits are all ones; a shorter tap never waits for a 16-bit wrap
  wire hit = i_en & tick & ((post_q & tap_last) == tap_last);
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      base_q <= 20'h00000;
      post_q <= 16'h0000;
      o_tmo <= 1'b0;
    end else begin
      o_tmo <= ~i_clr & hit;
      if (i_clr | ~i_en | hit) begin
        base_q <= 20'h00000;
        post_q <= 16'h0000;
      end else if (tick) begin
        base_q <= 20'h00000;
        post_q <= post_q + 16'h0001;
      end else begin
        base_q <= base_q + 20'h00001;
      end
    end
  end
endmodule // cfws_wdt

// File: bench/cfws_top_properties.sv
// Port-level checks for the fuse, watchdog and start-up block
`timescale 1ns/1ps
`include "cfws_defines.vh"
module cfws_props #(
  parameter WDT_BASE_CYC = 4
) (
  input wire I_CLOCK,
  input wire I_SYS_RST,
  input wire I_PWRITE,
  input wire I_STACK_FULL,
  input wire I_STACK_UNDERFLOW,
  input wire I_TBLRD_REQ,
  input wire I_TBLRD_FROM_EXT,
  input wire [20:0] I_TBLRD_ADDR,
  input wire I_SLEEP,
  input wire I_WATCHDOG_CLEAR_INSTR,
  input wire I_CLOCK_FAIL,
  input wire [31:0] O_PRDATA,
  input wire O_PREADY,
  input wire O_MASTER_RESET,
  input wire O_PORT_G_BIT5_IN_EN,
  input wire O_CAPTURE_COMPARE_UNIT2_ON_PORT_C_BIT1,
  input wire O_CAPTURE_COMPARE_UNIT2_ON_PORT_E_BIT7,
  input wire O_CAPTURE_COMPARE_UNIT2_ON_PORT_B_BIT3,
  input wire O_DEBUGGER_EN,
  input wire O_PORT_B_PINS_GPIO,
  input wire O_STACK_FAULT_RESET,
  input wire O_TBLRD_BLOCK,
  input wire O_WATCHDOG_RESET,
  input wire O_INTERNAL_RC_OSC_EN
);
  logic live_q;
  logic seen_q;
  logic [15:0] gap_q;
  // Decode outputs are only meaningful one edge after reset release
  always @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      live_q <= 1'b0;
      seen_q <= 1'b0;
      gap_q <= 16'h0000;
    end else begin
      live_q <= 1'b1;
      seen_q <= seen_q | O_WATCHDOG_RESET;
      gap_q <= O_WATCHDOG_RESET ? 16'h0000 : gap_q + {15'h0000, ~&gap_q};
    end
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_clear;
    I_SLEEP || I_WATCHDOG_CLEAR_INSTR || I_CLOCK_FAIL;
  endsequence
  a_pin_reset_excl: assert property (O_MASTER_RESET |-> !O_PORT_G_BIT5_IN_EN) else $error("pin both");
  a_ccp_route_onehot: assert property (live_q |-> $onehot({O_CAPTURE_COMPARE_UNIT2_ON_PORT_C_BIT1, O_CAPTURE_COMPARE_UNIT2_ON_PORT_E_BIT7,
    O_CAPTURE_COMPARE_UNIT2_ON_PORT_B_BIT3})) else $error("route not one-hot");
  a_debug_pins_split: assert property (live_q |-> O_DEBUGGER_EN != O_PORT_B_PINS_GPIO) else $error("pins");
  a_stack_cause: assert property ($rose(O_STACK_FAULT_RESET) |-> $past(I_STACK_FULL || I_STACK_UNDERFLOW))
    else $error("stack reset without cause");
  a_tblrd_cause: assert property (O_TBLRD_BLOCK |-> $past(I_TBLRD_REQ && I_TBLRD_FROM_EXT &&
    I_TBLRD_ADDR <= `CFWS_INTMEM_TOP)) else $error("block without cause");
  a_read_upper_zero: assert property (O_PREADY && !I_PWRITE |-> O_PRDATA[31:8] == 24'h000000) else $error("hi");
  a_wdt_osc_on: assert property (O_WATCHDOG_RESET |-> O_INTERNAL_RC_OSC_EN) else $error("rc off");
  a_wdt_min_gap: assert property (O_WATCHDOG_RESET && seen_q |-> gap_q >= WDT_BASE_CYC - 1) else $error("gap");
  a_wdt_clear_quiet: assert property (s_clear |-> ##2 !O_WATCHDOG_RESET [*2]) else $error("after clear");
endmodule // cfws_props

// File: bench/cfws_top_tb.sv
// Self-checking bench for fuse decode, protection, watchdog and start-up
`timescale 1ns/1ps
`include "cfws_defines.vh"
module cfws_top_tb;
  localparam int BASE = 4;
  logic I_CLOCK = 0, I_SYS_RST = 1, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0, I_MASTER_CLEAR_PIN_N = 1;
  logic I_OST_DONE = 0, I_PWRT_DONE = 1, I_SLEEP = 0, I_WATCHDOG_CLEAR_INSTR = 0, I_CLOCK_FAIL = 0;
  logic I_WAKE = 0, I_STACK_FULL = 0, I_STACK_UNDERFLOW = 0, I_TBLRD_REQ = 0, I_TBLRD_FROM_EXT = 0;
  logic [20:0] I_TBLRD_ADDR = 0;
  logic [23:0] I_PADDR = 0;
  logic [31:0] I_PWDATA = 0, rd;
  logic er;
  wire [31:0] O_PRDATA;
  wire [2:0] O_INTERNAL_OSC_FREQ_SELECT;
  wire O_PREADY, O_PSLVERR, O_MASTER_RESET, O_PORT_G_BIT5_IN_EN, O_PORT_G_BIT5_DATA, O_TIMER1_LOW_POWER_OSC;
  wire O_CAPTURE_COMPARE_UNIT2_ON_PORT_C_BIT1, O_CAPTURE_COMPARE_UNIT2_ON_PORT_E_BIT7, O_CAPTURE_COMPARE_UNIT2_ON_PORT_B_BIT3, O_DEBUGGER_EN, O_PORT_B_PINS_GPIO;
  wire O_EXTENDED_INSTR_EN, O_STACK_FAULT_RESET, O_TBLRD_BLOCK, O_WATCHDOG_RESET, O_INTERNAL_RC_OSC_EN;
  wire O_CORE_ON_INTERNAL_OSC;
  int err_total = 0, num_checks = 0, wd_cnt = 0, g;
  always #2.5 I_CLOCK = ~I_CLOCK;
  // Counted on the falling edge so the count never races the bench
  always @(negedge I_CLOCK) if (O_WATCHDOG_RESET === 1'b1) wd_cnt++;
  cfws_top #(.WDT_BASE_CYC(BASE)) DUT (.*);
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic bad(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) bad($sformatf("got %h want %h", got, exp));
  endtask
  task automatic chk_b(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) bad($sformatf("bit %b want %b", got, exp));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge I_CLOCK);
  endtask
  task automatic apb(input logic w, input logic [21:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    I_PSEL <= 1'b1;
    I_PWRITE <= w;
    I_PADDR <= {idx, 2'b00};
    I_PWDATA <= {24'h000000, d};
    tick(1);
    I_PENABLE <= 1'b1;
    do begin
      tick(1);
      n++;
    end while (O_PREADY !== 1'b1 && n < 20);
    if (O_PREADY !== 1'b1) begin
      bad("bus hang");
      close_out;
    end else begin
      rd = O_PRDATA;
      er = O_PSLVERR;
      I_PSEL <= 1'b0;
      I_PENABLE <= 1'b0;
      tick(1);
    end
  endtask
  task automatic rdc(input logic [21:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk_w(rd, {24'h000000, e});
  endtask
  task automatic gap(output int n);
    int k;
    k = 0;
    while (O_WATCHDOG_RESET !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    n = 0;
    do begin
      tick(1);
      n++;
    end while (O_WATCHDOG_RESET !== 1'b1 && n < 200);
    if (O_WATCHDOG_RESET !== 1'b1) begin
      bad("watchdog silent");
      close_out;
    end
  endtask
  task automatic tbl(input logic [1:0] md, input logic ext, input logic [20:0] a, input logic e);
    apb(1'b1, `CFWS_IDX_CFG3L, {6'h00, md});
    I_TBLRD_REQ <= 1'b1;
    I_TBLRD_FROM_EXT <= ext;
    I_TBLRD_ADDR <= a;
    tick(2);
    chk_b(O_TBLRD_BLOCK, e);
    I_TBLRD_REQ <= 1'b0;
  endtask
  task automatic stk(input logic e);
    I_STACK_FULL <= 1'b1;
    tick(1);
    I_STACK_FULL <= 1'b0;
    tick(1);
    chk_b(O_STACK_FAULT_RESET, e);
    I_STACK_UNDERFLOW <= 1'b1;
    tick(1);
    I_STACK_UNDERFLOW <= 1'b0;
    tick(1);
    chk_b(O_STACK_FAULT_RESET, e);
  endtask
  task automatic pulse_wake;
    I_WAKE <= 1'b1;
    tick(1);
    I_WAKE <= 1'b0;
    tick(6);
  endtask
  task automatic t_regs;
    rdc(`CFWS_IDX_CFG3H, 8'h81);
    rdc(`CFWS_IDX_CFG4L, 8'h81);
    rdc(`CFWS_IDX_CFG5L, 8'h01);
    rdc(`CFWS_IDX_CFG7L, 8'h01);
    rdc(`CFWS_IDX_WATCHDOG_CONTROL, 8'h00);
    apb(1'b1, `CFWS_IDX_ID1, 8'h00);
    rdc(`CFWS_IDX_ID1, 8'hA3);
    rdc(`CFWS_IDX_ID2, 8'h54);
    rdc(22'h000103, 8'h00);
    chk_b(er, 1'b1);
    chk_b(O_PORT_B_PINS_GPIO, 1'b1);
    chk_b(O_CAPTURE_COMPARE_UNIT2_ON_PORT_C_BIT1, 1'b1);
    chk_b(O_TIMER1_LOW_POWER_OSC, 1'b0);
    chk_b(O_EXTENDED_INSTR_EN, 1'b0);
    chk_b(O_INTERNAL_RC_OSC_EN, 1'b1);
  endtask
  task automatic t_fuses;
    apb(1'b1, `CFWS_IDX_CFG3H, 8'hFF);
    rdc(`CFWS_IDX_CFG3H, 8'h85);
    I_MASTER_CLEAR_PIN_N <= 1'b0;
    tick(4);
    chk_b(O_TIMER1_LOW_POWER_OSC, 1'b1);
    chk_b(O_MASTER_RESET, 1'b1);
    apb(1'b1, `CFWS_IDX_CFG3H, 8'h04);
    tick(2);
    chk_b(O_MASTER_RESET, 1'b0);
    chk_b(O_PORT_G_BIT5_IN_EN, 1'b1);
    chk_b(O_CAPTURE_COMPARE_UNIT2_ON_PORT_E_BIT7, 1'b1);
    apb(1'b1, `CFWS_IDX_CFG3L, 8'h00);
    I_MASTER_CLEAR_PIN_N <= 1'b1;
    tick(4);
    chk_b(O_PORT_G_BIT5_DATA, 1'b1);
    chk_b(O_CAPTURE_COMPARE_UNIT2_ON_PORT_B_BIT3, 1'b1);
    apb(1'b1, `CFWS_IDX_CFG4L, 8'h40);
    stk(1'b0);
    chk_b(O_DEBUGGER_EN, 1'b1);
    chk_b(O_EXTENDED_INSTR_EN, 1'b1);
    apb(1'b1, `CFWS_IDX_CFG4L, 8'h01);
    stk(1'b1);
  endtask
  task automatic t_protect;
    apb(1'b1, `CFWS_IDX_CFG5L, 8'h00);
    apb(1'b1, `CFWS_IDX_CFG5L, 8'h01);
    rdc(`CFWS_IDX_CFG5L, 8'h00);
    apb(1'b1, `CFWS_IDX_CFG7L, 8'h00);
    tbl(2'h0, 1'b1, 21'h001234, 1'b1);
    tbl(2'h0, 1'b0, 21'h001234, 1'b0);
    tbl(2'h1, 1'b1, 21'h0007FF, 1'b1);
    tbl(2'h1, 1'b1, 21'h000800, 1'b0);
    tbl(2'h2, 1'b1, 21'h000000, 1'b0);
    tbl(2'h3, 1'b1, 21'h000000, 1'b0);
  endtask
  task automatic t_wdt;
    int i;
    for (i = 0; i < 3; i++) begin
      apb(1'b1, `CFWS_IDX_CFG2H, {3'h0, i[3:0], 1'b1});
      gap(g);
      chk_w(g, BASE << i);
    end
    for (i = 0; i < 12; i++) begin
      {I_SLEEP, I_WATCHDOG_CLEAR_INSTR, I_CLOCK_FAIL} <= 3'h4 >> (i % 3);
      tick(1);
      {I_SLEEP, I_WATCHDOG_CLEAR_INSTR, I_CLOCK_FAIL} <= 3'h0;
      tick(3);
      if (i == 0) g = wd_cnt;
    end
    chk_w(wd_cnt - g, 0);
    g = wd_cnt;
    for (i = 0; i < 10; i++) apb(1'b1, `CFWS_IDX_OSCCTL, {7'h00, i[0]} + 8'h01);
    chk_w(wd_cnt - g, 0);
    chk_w({29'h0, O_INTERNAL_OSC_FREQ_SELECT}, 32'h2);
    apb(1'b1, `CFWS_IDX_CFG2H, 8'h02);
    tick(2);
    chk_b(O_INTERNAL_RC_OSC_EN, 1'b0);
    g = wd_cnt;
    tick(40);
    chk_w(wd_cnt - g, 0);
    apb(1'b1, `CFWS_IDX_WATCHDOG_CONTROL, 8'hFF);
    rdc(`CFWS_IDX_WATCHDOG_CONTROL, 8'h01);
    chk_b(O_INTERNAL_RC_OSC_EN, 1'b1);
    gap(g);
    chk_w(g, 2 * BASE);
    apb(1'b1, `CFWS_IDX_CFG2H, 8'h03);
    apb(1'b1, `CFWS_IDX_WATCHDOG_CONTROL, 8'h00);
    gap(g);
    chk_w(g, 2 * BASE);
  endtask
  task automatic t_boot;
    pulse_wake;
    chk_b(O_CORE_ON_INTERNAL_OSC, 1'b0);
    apb(1'b1, `CFWS_IDX_CFG1H, 8'h80);
    apb(1'b1, `CFWS_IDX_OSCCTL, 8'h05);
    I_PWRT_DONE <= 1'b0;
    pulse_wake;
    chk_b(O_CORE_ON_INTERNAL_OSC, 1'b0);
    I_PWRT_DONE <= 1'b1;
    tick(4);
    chk_b(O_CORE_ON_INTERNAL_OSC, 1'b1);
    chk_w({29'h0, O_INTERNAL_OSC_FREQ_SELECT}, 32'h5);
    rdc(`CFWS_IDX_STATUS, 8'h0E);
    I_OST_DONE <= 1'b1;
    tick(6);
    chk_b(O_CORE_ON_INTERNAL_OSC, 1'b0);
    I_OST_DONE <= 1'b0;
    I_SLEEP <= 1'b1;
    tick(1);
    I_SLEEP <= 1'b0;
    tick(6);
    chk_b(O_CORE_ON_INTERNAL_OSC, 1'b0);
  endtask
  initial begin
    tick(2);
    I_SYS_RST <= 1'b0;
    tick(2);
    t_regs;
    t_fuses;
    t_protect;
    t_wdt;
    t_boot;
    close_out;
  end
endmodule // cfws_top_tb
bind cfws_top cfws_props #(.WDT_BASE_CYC(WDT_BASE_CYC)) u_props (
  .I_CLOCK(I_CLOCK),
  .I_SYS_RST(I_SYS_RST),
  .I_PWRITE(I_PWRITE),
  .I_STACK_FULL(I_STACK_FULL),
  .I_STACK_UNDERFLOW(I_STACK_UNDERFLOW),
  .I_TBLRD_REQ(I_TBLRD_REQ),
  .I_TBLRD_FROM_EXT(I_TBLRD_FROM_EXT),
  .I_TBLRD_ADDR(I_TBLRD_ADDR),
  .I_SLEEP(I_SLEEP),
  .I_WATCHDOG_CLEAR_INSTR(I_WATCHDOG_CLEAR_INSTR),
  .I_CLOCK_FAIL(I_CLOCK_FAIL),
  .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY),
  .O_MASTER_RESET(O_MASTER_RESET),
  .O_PORT_G_BIT5_IN_EN(O_PORT_G_BIT5_IN_EN),
  .O_CAPTURE_COMPARE_UNIT2_ON_PORT_C_BIT1(O_CAPTURE_COMPARE_UNIT2_ON_PORT_C_BIT1),
  .O_CAPTURE_COMPARE_UNIT2_ON_PORT_E_BIT7(O_CAPTURE_COMPARE_UNIT2_ON_PORT_E_BIT7),
  .O_CAPTURE_COMPARE_UNIT2_ON_PORT_B_BIT3(O_CAPTURE_COMPARE_UNIT2_ON_PORT_B_BIT3),
  .O_DEBUGGER_EN(O_DEBUGGER_EN),
  .O_PORT_B_PINS_GPIO(O_PORT_B_PINS_GPIO),
  .O_STACK_FAULT_RESET(O_STACK_FAULT_RESET),
  .O_TBLRD_BLOCK(O_TBLRD_BLOCK),
  .O_WATCHDOG_RESET(O_WATCHDOG_RESET),
  .O_INTERNAL_RC_OSC_EN(O_INTERNAL_RC_OSC_EN)
);
